// ===== core_event_prioritizer.sv
// Core event prioritizer: latches, ranks, nests and enters core events.
// Assumes one core clock, synchronous reset, and request inputs that are
// already synchronous to the core clock.
//
// Summary of operation
// - The highest priority pending event is always serviced first.
// - Higher priority events preempt running handlers, so handlers nest.
// - Emulation, reset, NMI, exception and interrupt classes are handled.
// - Entering the emulation event puts the processor in emulation mode.
// - Taking the reset event resets the whole processor.
// - Watchdog expiry or the external NMI pin raises the NMI event.
// - Exceptions stall completion of the faulting instruction until taken.
// - Interrupts come from timers, peripherals, pins and software raise.
// - Each level but reset keeps a return address; a return restores it.
// - Processor state is pushed to the supervisor stack on entry.
// - Peripheral requests arrive from the router on general lines.
// - Nine general levels, 7 to 15, sit below the dedicated events.
// - Fixed priority 0 highest to 15 lowest, in class order.
// - The router's remappable mapping feeds the general levels as given.
`timescale 1ns/1ps
module core_event_prioritizer
    import event_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                sys_rst,
    input  wire logic                emu_req,
    input  wire logic                rst_req,
    input  wire logic                wdog_expire,
    input  wire logic                nmi_pin,
    input  wire logic                exc_req,
    input  wire logic                hw_err_req,
    input  wire logic                core_tick_req,
    input  wire logic [NUM_GEN-1:0]  general_levels,
    input  wire logic                sw_raise_valid,
    input  wire logic [LVL_W-1:0]    sw_raise_level,
    input  wire logic                global_en,
    input  wire logic [ADDR_W-1:0]   cur_pc,
    input  wire logic [ADDR_W-1:0]   proc_status,
    input  wire logic                rtx_valid,
    input  wire logic [LVL_W-1:0]    rtx_level,
    output logic                     rtx_ready,
    output logic                     commit_hold,
    output logic                     stack_push,
    output logic [ADDR_W-1:0]        stack_data,
    output logic                     event_take,
    output logic [LVL_W-1:0]         event_level,
    output logic                     proc_reset,
    output logic                     emu_mode,
    output logic                     ret_valid,
    output logic [ADDR_W-1:0]        ret_addr,
    output logic [NUM_LEVELS-1:0]    pending,
    output logic [NUM_LEVELS-1:0]    active
);
    // ==============================================================
    // Helpers
    // Index of the most urgent set bit, or NO_LEVEL when none is set.
    function automatic logic [4:0] first_set(input logic [15:0] v);
        logic [4:0] r;
        r = NO_LEVEL;
        for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    // One-hot vector for a level number.
    function automatic logic [15:0] lvl_bit(input logic [3:0] lvl);
        return 16'h0001 << lvl;
    endfunction

    // ==============================================================
    // State
    entry_state_t            state_ff, nxt_state;
    logic [15:0]             pend_ff, nxt_pend;
    logic [15:0]             act_ff, nxt_act;
    logic [3:0]              sel_ff, nxt_sel;
    logic                    push_ff, nxt_push;
    logic [ADDR_W-1:0]       sdata_ff, nxt_sdata;
    logic                    take_ff, nxt_take;
    logic [3:0]              lvl_ff, nxt_lvl;
    logic                    prst_ff, nxt_prst;
    logic                    emu_ff, nxt_emu;
    logic                    rvalid_ff, nxt_rvalid;
    logic [15:0]             set_vec;
    logic [15:0]             pend_eff;
    logic [4:0]              win;
    logic [4:0]              top_act;
    logic                    take_go;
    logic                    ret_go;

    ret_addr_if #(.AW(LVL_W), .DW(ADDR_W)) ra_bus ();

    return_addr_store #(
        .DEPTH (NUM_LEVELS),
        .AW    (LVL_W),
        .DW    (ADDR_W)
    ) u_store (
        .core_clk (core_clk),
        .port     (ra_bus.mem)
    );

    // ==============================================================
    // Request capture and ranking
    // Gather every source into one vector; level 4 is never pending.
    always_comb begin
        set_vec            = VEC_RST;
        set_vec[LVL_EMU]   = emu_req;
        set_vec[LVL_RST]   = rst_req;
        set_vec[LVL_NMI]   = wdog_expire | nmi_pin;
        set_vec[LVL_EXC]   = exc_req;
        set_vec[LVL_HWERR] = hw_err_req;
        set_vec[LVL_TICK]  = core_tick_req;
        set_vec[15:7]      = general_levels;
        if (sw_raise_valid && sw_raise_level >= LVL_GEN_LO) begin
            set_vec = set_vec | lvl_bit(sw_raise_level);
        end
    end

    // Global enable masks everything below its own priority slot.
    assign pend_eff = global_en ? pend_ff : (pend_ff & ~GATED_MASK);
    assign win      = first_set(pend_eff);
    assign top_act  = first_set(act_ff);
    assign ret_go   = rtx_valid && state_ff == ST_IDLE;
    assign take_go  = state_ff == ST_IDLE && !rtx_valid
                      && win < top_act;
    assign rtx_ready   = state_ff == ST_IDLE;
    assign commit_hold = exc_req | pend_ff[LVL_EXC];

    // ==============================================================
    // Return address store access
    // Capture the interrupted PC on the decision cycle; read on return.
    always_comb begin
        ra_bus.wr_en   = take_go && win[3:0] != LVL_RST;
        ra_bus.wr_idx  = win[3:0];
        ra_bus.wr_data = cur_pc;
        ra_bus.rd_en   = ret_go;
        ra_bus.rd_idx  = rtx_level;
    end

    // ==============================================================
    // Entry sequencer next state
    // Decide, push state, then enter the handler; returns only in idle.
    always_comb begin
        nxt_state  = state_ff;
        nxt_pend   = pend_ff | set_vec;
        nxt_act    = act_ff;
        nxt_sel    = sel_ff;
        nxt_push   = 1'b0;
        nxt_sdata  = sdata_ff;
        nxt_take   = 1'b0;
        nxt_lvl    = lvl_ff;
        nxt_prst   = 1'b0;
        nxt_emu    = emu_ff;
        nxt_rvalid = 1'b0;
        unique case (state_ff)
            ST_IDLE: begin
                if (ret_go) begin
                    nxt_act    = act_ff & ~lvl_bit(rtx_level);
                    nxt_rvalid = 1'b1;
                    if (rtx_level == LVL_EMU) begin
                        nxt_emu = 1'b0;
                    end
                end else if (take_go && win[3:0] == LVL_RST) begin
                    nxt_prst = 1'b1;
                    nxt_pend = set_vec & ~lvl_bit(LVL_RST);
                    nxt_act  = VEC_RST;
                    nxt_emu  = 1'b0;
                end else if (take_go) begin
                    nxt_sel   = win[3:0];
                    nxt_push  = 1'b1;
                    nxt_sdata = proc_status;
                    nxt_state = ST_PUSH;
                end
            end
            ST_PUSH: begin
                // Clear before set so a fresh request is kept.
                nxt_pend  = (pend_ff & ~lvl_bit(sel_ff)) | set_vec;
                nxt_act   = act_ff | lvl_bit(sel_ff);
                nxt_take  = 1'b1;
                nxt_lvl   = sel_ff;
                nxt_state = ST_ENTER;
                if (sel_ff == LVL_EMU) begin
                    nxt_emu = 1'b1;
                end
            end
            ST_ENTER: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Register the sequencer state.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff  <= ST_IDLE;
            pend_ff   <= VEC_RST;
            act_ff    <= VEC_RST;
            sel_ff    <= LVL_EMU;
            push_ff   <= 1'b0;
            sdata_ff  <= WORD_RST;
            take_ff   <= 1'b0;
            lvl_ff    <= LVL_EMU;
            prst_ff   <= 1'b0;
            emu_ff    <= 1'b0;
            rvalid_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            pend_ff   <= nxt_pend;
            act_ff    <= nxt_act;
            sel_ff    <= nxt_sel;
            push_ff   <= nxt_push;
            sdata_ff  <= nxt_sdata;
            take_ff   <= nxt_take;
            lvl_ff    <= nxt_lvl;
            prst_ff   <= nxt_prst;
            emu_ff    <= nxt_emu;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // ==============================================================
    // Outputs
    // All data outputs but rtx_ready and commit_hold come straight from flip-flops.
    assign stack_push  = push_ff;
    assign stack_data  = sdata_ff;
    assign event_take  = take_ff;
    assign event_level = lvl_ff;
    assign proc_reset  = prst_ff;
    assign emu_mode    = emu_ff;
    assign ret_valid   = rvalid_ff;
    assign ret_addr    = ra_bus.rd_data;
    assign pending     = pend_ff;
    assign active      = act_ff;

    // ==============================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Bits of pend_eff more urgent than the winner.
    logic [15:0] above_win;
    assign above_win = pend_eff & (lvl_bit(win[3:0]) - 16'h0001);

    property p_first_wins;
        take_go |-> above_win == VEC_RST;
    endproperty
    a_first_wins: assert property (p_first_wins)
        else $error("A more urgent pending event was passed over.");

    property p_nest_mark;
        event_take |-> active[event_level];
    endproperty
    a_nest_mark: assert property (p_nest_mark)
        else $error("Entered level is not marked active.");

    property p_entry_seq;
        take_go && win[3:0] != LVL_RST |=> stack_push ##1 event_take;
    endproperty
    a_entry_seq: assert property (p_entry_seq)
        else $error("Entry did not push state then enter.");

    property p_emu_enter;
        event_take && event_level == LVL_EMU |-> emu_mode;
    endproperty
    a_emu_enter: assert property (p_emu_enter)
        else $error("Emulation entry left emulation mode off.");

    property p_reset_clear;
        proc_reset |-> active == VEC_RST && !emu_mode;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("Reset event left handlers active.");

    property p_nmi_latch;
        wdog_expire || nmi_pin |=> pending[LVL_NMI];
    endproperty
    a_nmi_latch: assert property (p_nmi_latch)
        else $error("NMI source was not latched.");

    property p_exc_hold;
        pending[LVL_EXC] |=> commit_hold || proc_reset
            || (event_take && event_level == LVL_EXC);
    endproperty
    a_exc_hold: assert property (p_exc_hold)
        else $error("Pending exception did not hold completion.");

    property p_sw_raise;
        sw_raise_valid && sw_raise_level >= LVL_GEN_LO
            |=> pending[$past(sw_raise_level)];
    endproperty
    a_sw_raise: assert property (p_sw_raise)
        else $error("Software raise was not latched.");

    property p_return;
        rtx_valid && rtx_ready |=> ret_valid
            && !active[$past(rtx_level)];
    endproperty
    a_return: assert property (p_return)
        else $error("Return did not answer or release its level.");

    property p_gen_latch;
        general_levels[0] |=> pending[LVL_GEN_LO];
    endproperty
    a_gen_latch: assert property (p_gen_latch)
        else $error("General request pulse was lost.");

    property p_above_active;
        event_take |-> (active & (lvl_bit(event_level) - 16'h0001))
            == VEC_RST;
    endproperty
    a_above_active: assert property (p_above_active)
        else $error("Event taken at or below an active handler.");

    // Main scenarios.
    c_nested:   cover property (event_take && $countones(active) > 1);
    c_reset:    cover property (proc_reset);
    c_return:   cover property (ret_valid);
    c_emu_take: cover property (event_take && event_level == LVL_EMU);
endmodule

// ===== event_pkg.sv
// Constants and types shared by the core event prioritizer and its store.
// Assumes a single core clock domain and a synchronous active-high reset.
package event_pkg;
    // ==============================================================
    // Levels and widths
    localparam int         NUM_LEVELS = 16;
    localparam int         LVL_W      = 4;
    localparam int         ADDR_W     = 32;
    localparam int         NUM_GEN    = 9;
    localparam logic [3:0] LVL_EMU    = 4'h0;
    localparam logic [3:0] LVL_RST    = 4'h1;
    localparam logic [3:0] LVL_NMI    = 4'h2;
    localparam logic [3:0] LVL_EXC    = 4'h3;
    localparam logic [3:0] LVL_GEN_EN = 4'h4;
    localparam logic [3:0] LVL_HWERR  = 4'h5;
    localparam logic [3:0] LVL_TICK   = 4'h6;
    localparam logic [3:0] LVL_GEN_LO = 4'h7;
    localparam logic [4:0] NO_LEVEL   = 5'h10;
    // ==============================================================
    // Masks and reset values
    localparam logic [15:0] GATED_MASK = 16'hFFE0;
    localparam logic [15:0] VEC_RST    = 16'h0000;
    localparam logic [31:0] WORD_RST   = 32'h0000_0000;
    // ==============================================================
    // Entry sequencer states, Gray coded along the entry path
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_PUSH  = 2'b01,
        ST_ENTER = 2'b11
    } entry_state_t;
endpackage

// ===== ret_addr_if.sv
// Carrier between the prioritizer and its return address store.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface ret_addr_if #(parameter int AW = 4, parameter int DW = 32);
    logic          wr_en;
    logic [AW-1:0] wr_idx;
    logic [DW-1:0] wr_data;
    logic          rd_en;
    logic [AW-1:0] rd_idx;
    logic [DW-1:0] rd_data;
    modport ctrl (output wr_en, wr_idx, wr_data, rd_en, rd_idx,
                  input  rd_data);
    modport mem  (input  wr_en, wr_idx, wr_data, rd_en, rd_idx,
                  output rd_data);
endinterface

// ===== return_addr_store.sv
// One return address word per event level, read data from a register.
// Assumes one write and one read port on the core clock.
`timescale 1ns/1ps
module return_addr_store #(
    parameter int DEPTH = 16,
    parameter int AW    = 4,
    parameter int DW    = 32
) (
    input wire logic core_clk,
    ret_addr_if.mem  port
);
    logic [DW-1:0] words_ff [DEPTH];
    logic [DW-1:0] rd_data_ff;

    // ==============================================================
    // Storage
    // Write on entry, registered read on return.
    always_ff @(posedge core_clk) begin
        if (port.wr_en) begin
            words_ff[port.wr_idx] <= port.wr_data;
        end
        if (port.rd_en) begin
            rd_data_ff <= words_ff[port.rd_idx];
        end
    end

    assign port.rd_data = rd_data_ff;
endmodule

// ===== system_irq_router.sv
// Behavioural model of the system interrupt router feeding the prioritizer.
// Assumes the core clock and seven peripheral request lines from the bench.
`timescale 1ns/1ps
module system_irq_router
    import event_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic [6:0]        periph,
    input  wire logic              slow,
    output logic [NUM_GEN-1:0]     general_levels
);
    // ==============================================================
    // Routing table and request merge
    logic [3:0]         map [7];
    logic [NUM_GEN-1:0] routed;
    logic [NUM_GEN-1:0] routed_ff;

    // Sources start on levels 7 to 13 so 14 and 15 stay free for software.
    initial begin
        for (int i = 0; i < 7; i++) begin
            map[i] = 4'h7 + 4'(i);
        end
    end

    // Every active source drives the general line of its target level.
    always_comb begin
        routed = '0;
        for (int i = 0; i < 7; i++) begin
            if (periph[i]) begin
                routed[map[i] - 4'h7] = 1'b1;
            end
        end
    end

    // A slow router answers one cycle late.
    always_ff @(posedge core_clk) begin
        routed_ff <= routed;
    end
    assign general_levels = slow ? routed_ff : routed;
endmodule

// ===== tb_core_event_prioritizer.sv
// Self-checking bench for the core event prioritizer.
// Assumes the router model drives the general request lines.
`timescale 1ns/1ps
module tb_core_event_prioritizer
    import event_pkg::*;
;
    // ==============================================================
    // Signals and expectation queues
    logic                  core_clk, sys_rst, emu_req, rst_req, nmi_pin;
    logic                  wdog_expire, exc_req, hw_err_req, core_tick_req;
    logic                  sw_raise_valid, global_en, rtx_valid, slow;
    logic                  rtx_ready, commit_hold, stack_push, event_take;
    logic                  proc_reset, emu_mode, ret_valid, wd_sel;
    logic [6:0]            periph;
    logic [NUM_GEN-1:0]    general_levels;
    logic [LVL_W-1:0]      sw_raise_level, rtx_level, event_level, exp_l;
    logic [ADDR_W-1:0]     cur_pc, proc_status, stack_data, ret_addr, exp_a;
    logic [NUM_LEVELS-1:0] pending, active;
    logic [ADDR_W-1:0]     pc_of [NUM_LEVELS];
    logic [LVL_W-1:0]      exp_lvl [$];
    logic [ADDR_W-1:0]     exp_stk [$];
    logic [ADDR_W-1:0]     exp_ret [$];
    int                    error_cnt = 0;
    int                    checks = 0;
    int                    cycles = 0;
    int                    lv_list [13] = '{2, 3, 5, 6, 7, 8, 9, 10, 11,
                                            12, 13, 14, 15};
    int                    pr_list [5] = '{2, 5, 6, 9, 15};

    core_event_prioritizer core_event_prioritizer_i (
        .core_clk, .sys_rst, .emu_req, .rst_req, .wdog_expire, .nmi_pin,
        .exc_req, .hw_err_req, .core_tick_req, .general_levels,
        .sw_raise_valid, .sw_raise_level, .global_en, .cur_pc, .proc_status,
        .rtx_valid, .rtx_level, .rtx_ready, .commit_hold, .stack_push,
        .stack_data, .event_take, .event_level, .proc_reset, .emu_mode,
        .ret_valid, .ret_addr, .pending, .active);
    system_irq_router system_irq_router_i (
        .core_clk, .periph, .slow, .general_levels);

    // Free-running core clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ==============================================================
    // Reporting
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // Takes the oldest note off a queue whenever a result shows.
    always @(negedge core_clk) begin
        if (sys_rst === 1'b0) begin
            if (stack_push === 1'b1) begin
                exp_a = (exp_stk.size() > 0) ? exp_stk.pop_front() : 'x;
                check("stack_data", stack_data, exp_a);
            end
            if (event_take === 1'b1 || proc_reset === 1'b1) begin
                exp_l = (exp_lvl.size() > 0) ? exp_lvl.pop_front() : 'x;
                if (proc_reset === 1'b1) begin
                    check("reset level", LVL_RST, exp_l);
                end else begin
                    check("event_level", event_level, exp_l);
                end
            end
            if (ret_valid === 1'b1) begin
                exp_a = (exp_ret.size() > 0) ? exp_ret.pop_front() : 'x;
                check("ret_addr", ret_addr, exp_a);
            end
        end
    end

    // ==============================================================
    // Drivers
    task automatic arm(input int lvl);
        pc_of[lvl] = $urandom;
        cur_pc = pc_of[lvl];
        proc_status = $urandom;
        exp_lvl.push_back(4'(lvl));
        exp_stk.push_back(proc_status);
    endtask

    task automatic raise(input int lvl);
        @(negedge core_clk);
        case (lvl)
            0: emu_req = 1'b1;
            1: rst_req = 1'b1;
            2: {wdog_expire, nmi_pin} = wd_sel ? 2'b10 : 2'b01;
            3: exc_req = 1'b1;
            5: hw_err_req = 1'b1;
            6: core_tick_req = 1'b1;
            14, 15: begin
                sw_raise_valid = 1'b1;
                sw_raise_level = 4'(lvl);
            end
            default: periph[lvl-7] = 1'b1;
        endcase
        @(negedge core_clk);
        {emu_req, rst_req, wdog_expire, nmi_pin, hw_err_req} = '0;
        {core_tick_req, sw_raise_valid, periph} = '0;
    endtask

    // Waits for an entry; an exception is held until its state is pushed.
    task automatic wait_ev();
        int n;
        n = 0;
        while (event_take !== 1'b1 && proc_reset !== 1'b1 && n < 40) begin
            if (exc_req === 1'b1) check("commit_hold", commit_hold, 1);
            if (stack_push === 1'b1) exc_req = 1'b0;
            @(negedge core_clk);
            n++;
        end
        check("entry seen", 32'(n < 40), 1);
    endtask

    task automatic ret(input int lvl);
        int n;
        exp_ret.push_back(pc_of[lvl]);
        rtx_valid = 1'b1;
        rtx_level = 4'(lvl);
        n = 0;
        while (rtx_ready !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        rtx_valid = 1'b0;
    endtask

    // ==============================================================
    // Main sequence
    initial begin
        {emu_req, rst_req, wdog_expire, nmi_pin, exc_req, hw_err_req} = '0;
        {core_tick_req, sw_raise_valid, rtx_valid, slow, wd_sel} = '0;
        {periph, sw_raise_level, rtx_level} = '0;
        {cur_pc, proc_status} = '0;
        global_en = 1'b1;
        sys_rst = 1'b1;
        void'($urandom(32'h8465));
        repeat (16) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        check("pending", pending, 0);
        check("active", {active, 15'h0000, rtx_ready}, 1);
        // Every level but 0, 1 and 4 alone, each twice, router speed random, NMI source alternating.
        repeat (2) begin
            foreach (lv_list[k]) begin
                slow = 1'($urandom);
                wd_sel = ~wd_sel;
                arm(lv_list[k]);
                raise(lv_list[k]);
                wait_ev();
                ret(lv_list[k]);
            end
        end
        // Five pulses in one cycle are latched and entered by rank.
        slow = 1'b0;
        arm(2);
        @(negedge core_clk);
        {nmi_pin, hw_err_req, core_tick_req, sw_raise_valid} = 4'hf;
        periph[2] = 1'b1;
        sw_raise_level = 4'hf;
        @(negedge core_clk);
        {nmi_pin, hw_err_req, core_tick_req, sw_raise_valid} = '0;
        periph = '0;
        foreach (pr_list[k]) begin
            wait_ev();
            if (k < 4) arm(pr_list[k+1]);
            ret(pr_list[k]);
        end
        // Nesting: 7 preempts 12, while 13 waits for both to finish.
        arm(12);
        raise(12);
        wait_ev();
        arm(7);
        raise(7);
        wait_ev();
        raise(13);
        repeat (8) @(negedge core_clk);
        check("pending 13", pending[13], 1);
        arm(13);
        ret(7);
        @(negedge core_clk);
        ret(12);
        wait_ev();
        ret(13);
        // Gate low holds level 8 but not NMI; software raise of 3 ignored.
        global_en = 1'b0;
        raise(8);
        @(negedge core_clk);
        sw_raise_valid = 1'b1;
        sw_raise_level = 4'h3;
        @(negedge core_clk);
        sw_raise_valid = 1'b0;
        arm(2);
        raise(2);
        wait_ev();
        ret(2);
        repeat (4) @(negedge core_clk);
        check("pending", pending, 16'h0100);
        arm(8);
        global_en = 1'b1;
        wait_ev();
        ret(8);
        // Remapped source 0 now lands on level 11.
        system_irq_router_i.map[0] = 4'hb;
        arm(11);
        raise(7);
        wait_ev();
        ret(11);
        system_irq_router_i.map[0] = 4'h7;
        // Emulation entry and its return.
        arm(0);
        raise(0);
        wait_ev();
        check("emu_mode", emu_mode, 1);
        ret(0);
        @(negedge core_clk);
        check("emu_mode", emu_mode, 0);
        // Reset event ends a running handler.
        arm(10);
        raise(10);
        wait_ev();
        exp_lvl.push_back(LVL_RST);
        raise(1);
        wait_ev();
        check("active", {active, pending}, 0);
        repeat (4) @(negedge core_clk);
        check("notes left", exp_lvl.size() + exp_ret.size(), 0);
        check("pushes left", exp_stk.size(), 0);
        end_of_test();
    end
endmodule
